// [core/sensor_device.sv]
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module sensor_device
    import thermal_pkg::*;
#(
    parameter int unsigned CONV_CYCLES = CONV_CYCLES_DEF,
    parameter logic [6:0]  DEV_ADDR    = 7'h2A, // Arbitrary value
    parameter int          ADC_W       = 10
) (
    input  wire logic                    clk,
    input  wire logic                    reset,
    sensor_link_if.device                link,
    output      logic                    adc_start,
    input  wire logic                    adc_done,
    input  wire logic signed [ADC_W-1:0] adc_temp_a,
    input  wire logic signed [ADC_W-1:0] adc_temp_b,
    input  wire logic                    adc_open_a,
    input  wire logic                    adc_open_b
);

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } conv_state_e;

    if (ADC_W < 9 || CONV_CYCLES < 2) begin : g_check
        $error("sensor_device: ADC_W or CONV_CYCLES too small");
    end

    logic [2:0]  lclk_q;
    logic [1:0]  frame_q;
    logic [1:0]  mosi_q;
    logic        rise;
    logic        fall;
    logic [4:0]  bit_cnt_q;
    logic [17:0] in_q;
    logic [7:0]  out_q;
    logic        miso_q;
    logic        done_q;
    link_op_e    op;
    logic [7:0]  cmd;
    logic [7:0]  dat;
    logic [7:0]  cfg_q;
    logic        alert_q;
    conv_state_e state_q;
    logic        oneshot_q;
    logic        adc_start_q;
    logic [31:0] ivl_q;
    logic        conv_done;
    logic        oneshot_req;
    logic        ara_ok;
    logic [7:0]  temp_q [2];
    logic [7:0]  high_q [2];
    logic [7:0]  low_q  [2];
    logic [2:0]  flag_q [2];
    logic [2:0]  cond_q [2];
    logic [1:0]  alert_set;
    logic [1:0]  alert_keep;

    // ************************************************************
    // Link pin synchronisers and edge detection
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            lclk_q  <= 3'h0;
            frame_q <= 2'h3;
            mosi_q  <= 2'h0;
        end else begin
            lclk_q  <= {lclk_q[1:0], link.link_clk};
            frame_q <= {frame_q[0], link.frame_n};
            mosi_q  <= {mosi_q[0], link.mosi};
        end
    end
    assign rise = lclk_q[1] & ~lclk_q[2];
    assign fall = ~lclk_q[1] & lclk_q[2];

    // Frame decode of the fully received frame
    assign op  = link_op_e'(in_q[17:16]);
    assign cmd = in_q[15:8];
    assign dat = in_q[7:0];

    // ************************************************************
    // Frame receiver
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset || frame_q[1]) begin
            bit_cnt_q <= 5'h00;
            in_q      <= 18'h00000;
            done_q    <= 1'b0;
        end else begin
            done_q <= rise && bit_cnt_q == 5'(FRAME_BITS - 1);
            if (rise && bit_cnt_q < 5'(FRAME_BITS)) begin
                in_q      <= {in_q[16:0], mosi_q[1]};
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
        end
    end

    // ARA is answered only while the alert is up and unmasked
    assign ara_ok = alert_q & ~cfg_q[CFG_MASK_BIT];

    // Read data mux on the command byte being completed
    function automatic logic [7:0] read_mux(input logic [7:0] c);
        logic [7:0] r;
        r = 8'h00;
        case (c)
            CMD_TEMP_A_RD: r = temp_q[0];
            CMD_TEMP_B_RD: r = temp_q[1];
            CMD_HIGH_A_RD: r = high_q[0];
            CMD_LOW_A_RD:  r = low_q[0];
            CMD_HIGH_B:    r = high_q[1];
            CMD_LOW_B:     r = low_q[1];
            CMD_CFG_RD:    r = cfg_q;
            CMD_STAT_A_RD: begin
                r[BUSY_BIT] = (state_q == ST_CONV);
                r[HIGH_BIT:OPEN_BIT] = flag_q[0];
            end
            CMD_STAT_B_RD: begin
                r[HIGH_BIT:OPEN_BIT] = flag_q[1];
                r[ALERT_BIT] = alert_q;
            end
            default:       r = 8'h00;
        endcase
        return r;
    endfunction

    // ************************************************************
    // Answer shifter, MSB first, changed on falling link edge
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset || frame_q[1]) begin
            out_q  <= 8'h00;
            miso_q <= 1'b0;
        end else if (rise && bit_cnt_q == 5'(HEAD_BITS - 1)) begin
            if (in_q[8:7] == OP_ARA) begin
                out_q <= ara_ok ? {DEV_ADDR, 1'b0} : NO_ANSWER;
            end else if (in_q[8:7] == OP_READ) begin
                out_q <= read_mux({in_q[6:0], mosi_q[1]});
            end else begin
                out_q <= 8'h00;
            end
        end else if (fall) begin
            miso_q <= out_q[7];
            out_q  <= {out_q[6:0], 1'b0};
        end
    end

    // ************************************************************
    // Configuration register
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_q <= CFG_RST;
        end else if (done_q && op == OP_WRITE && cmd == CMD_CFG_WR) begin
            cfg_q <= dat;
        end
    end

    // ************************************************************
    // Conversion sequencing
    // ************************************************************
    assign conv_done   = state_q == ST_CONV && adc_done;
    assign oneshot_req = done_q && op == OP_SEND && cmd == CMD_ONE_SHOT;

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q     <= ST_IDLE;
            oneshot_q   <= 1'b0;
            adc_start_q <= 1'b0;
            ivl_q       <= 32'h0;
        end else begin
            adc_start_q <= 1'b0;
            if (ivl_q < 32'(CONV_CYCLES - 1)) begin
                ivl_q <= ivl_q + 32'h1;
            end
            case (state_q)
                ST_IDLE: begin
                    if (oneshot_req) begin
                        state_q     <= ST_CONV;
                        oneshot_q   <= 1'b1;
                        adc_start_q <= 1'b1;
                        ivl_q       <= 32'h0;
                    end else if (!cfg_q[CFG_STANDBY_BIT] &&
                                 ivl_q == 32'(CONV_CYCLES - 1)) begin
                        state_q     <= ST_CONV;
                        adc_start_q <= 1'b1;
                        ivl_q       <= 32'h0;
                    end
                end
                ST_CONV: begin
                    if (adc_done) begin
                        state_q   <= ST_IDLE;
                        oneshot_q <= 1'b0;
                    end else if (cfg_q[CFG_STANDBY_BIT] && !oneshot_q) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Per-channel value, limits and alarm flags
    // ************************************************************
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        logic signed [ADC_W-1:0] raw;
        logic [7:0]              sat;
        logic [2:0]              cond_new;
        logic                    clr;
        logic [7:0]              hi_cmd;
        logic [7:0]              lo_cmd;
        logic                    lim_mask;

        assign raw = (ch == 0) ? adc_temp_a : adc_temp_b;
        assign hi_cmd = (ch == 0) ? CMD_HIGH_A_WR : CMD_HIGH_B;
        assign lo_cmd = (ch == 0) ? CMD_LOW_A_WR : CMD_LOW_B;
        // Clamp to 0..127, sign bit always zero
        assign sat = (raw < 0) ? 8'h00 :
                     (raw > ADC_W'(TEMP_MAX)) ? TEMP_MAX :
                     8'(raw);
        assign cond_new[2] = sat >= high_q[ch];
        assign cond_new[1] = sat <= low_q[ch];
        assign cond_new[0] = (ch == 0) ? adc_open_a : adc_open_b;
        assign clr = done_q && op == OP_READ &&
                     cmd == ((ch == 0) ? CMD_STAT_A_RD : CMD_STAT_B_RD);
        assign lim_mask = cfg_q[(ch == 0) ? CFG_MASK_A_BIT
                                          : CFG_MASK_B_BIT];
        assign alert_set[ch]  = conv_done &&
                                (|(cond_new[2:1] & {2{~lim_mask}}) ||
                                 cond_new[0]);
        assign alert_keep[ch] = |(cond_q[ch][2:1] & {2{~lim_mask}}) ||
                                cond_q[ch][0];

        // Limit registers
        always_ff @(posedge clk) begin
            if (reset) begin
                high_q[ch] <= LIMIT_HIGH_RST;
                low_q[ch]  <= LIMIT_LOW_RST;
            end else if (done_q && op == OP_WRITE) begin
                if (cmd == hi_cmd) begin
                    high_q[ch] <= dat;
                end
                if (cmd == lo_cmd) begin
                    low_q[ch] <= dat;
                end
            end
        end

        // Value, present condition and sticky flags
        always_ff @(posedge clk) begin
            if (reset) begin
                temp_q[ch] <= TEMP_RST;
                cond_q[ch] <= 3'h0;
                flag_q[ch] <= 3'h0;
            end else begin
                if (conv_done) begin
                    temp_q[ch] <= sat;
                    cond_q[ch] <= cond_new;
                end
                // Set wins over read clear
                flag_q[ch] <= (clr ? cond_q[ch] : flag_q[ch]) |
                              (conv_done ? cond_new : 3'h0);
            end
        end
    end

    // ************************************************************
    // Latched alert, released only by answered ARA
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            alert_q <= 1'b0;
        end else if (|alert_set && !cfg_q[CFG_MASK_BIT]) begin
            alert_q <= 1'b1;
        end else if (done_q && op == OP_ARA && ara_ok) begin
            alert_q <= |alert_keep;
        end
    end

    assign link.miso     = miso_q;
    assign link.alert_o  = 1'b0;
    assign link.alert_oe = alert_q;
    assign adc_start     = adc_start_q;

endmodule

// [shared/thermal_pkg.sv]
// Behaviour
// - Temperature stored as positive 8-bit whole degrees
// - Readings above 127 saturate to 127
// - Host reads sign-set values as zero
// - High and low limit per channel
// - Reaching a limit sets its alarm flag
// - Status read clears flags unless condition persists
// - Enabled alert drives open-drain alert line
// - First status bit 7 shows conversion busy
// - Core A high, low, open in bits 4..2
// - Core B high, low, open in bits 4..2
// - Second status bit 0 mirrors alert line
// - Config bit 7 masks alert and response
// - Config bit 6 stand-by, else timed conversions
// - Host keeps config bit 5 zero
// - Host keeps config bit 3 zero
// - Host keeps config bit 2 zero
// - Config bit 1 masks core A limit alerts
// - Config bit 0 masks core B limit alerts
// - One-shot starts conversion, ignored while busy
// - One-shot in stand-by converts once, returns
// - Only answered alert response releases alert
package thermal_pkg;

    // ************************************************************
    // Command codes
    // ************************************************************
    localparam logic [7:0] CMD_TEMP_A_RD   = 8'h01;
    localparam logic [7:0] CMD_STAT_A_RD   = 8'h02;
    localparam logic [7:0] CMD_CFG_RD      = 8'h03;
    localparam logic [7:0] CMD_HIGH_A_RD   = 8'h07;
    localparam logic [7:0] CMD_LOW_A_RD    = 8'h08;
    localparam logic [7:0] CMD_CFG_WR      = 8'h09;
    localparam logic [7:0] CMD_HIGH_A_WR   = 8'h0D;
    localparam logic [7:0] CMD_LOW_A_WR    = 8'h0E;
    localparam logic [7:0] CMD_ONE_SHOT    = 8'h0F;
    localparam logic [7:0] CMD_STAT_B_RD   = 8'h23;
    localparam logic [7:0] CMD_TEMP_B_RD   = 8'h30;
    localparam logic [7:0] CMD_HIGH_B      = 8'h31;
    localparam logic [7:0] CMD_LOW_B       = 8'h32;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BUSY_BIT        = 7;
    localparam int HIGH_BIT        = 4;
    localparam int LOW_BIT         = 3;
    localparam int OPEN_BIT        = 2;
    localparam int ALERT_BIT       = 0;
    localparam int CFG_MASK_BIT    = 7;
    localparam int CFG_STANDBY_BIT = 6;
    localparam int CFG_PINSEL_BIT  = 5;
    localparam int CFG_SWAP_BIT    = 3;
    localparam int CFG_RANGE_BIT   = 2;
    localparam int CFG_MASK_A_BIT  = 1;
    localparam int CFG_MASK_B_BIT  = 0;

    // ************************************************************
    // Reset values and encodings
    // ************************************************************
    localparam logic [7:0] TEMP_RST       = 8'h00;
    localparam logic [7:0] LIMIT_HIGH_RST = 8'h55;
    localparam logic [7:0] LIMIT_LOW_RST  = 8'h00;
    localparam logic [7:0] CFG_RST        = 8'h00;
    localparam logic [7:0] TEMP_MAX       = 8'h7F;
    localparam logic [7:0] NO_ANSWER      = 8'hFF;

    // ************************************************************
    // Link frame: 2-bit op, command byte, data byte
    // ************************************************************
    localparam int FRAME_BITS = 18;
    localparam int HEAD_BITS  = 10;
    typedef enum logic [1:0] {
        OP_WRITE = 2'b00,
        OP_READ  = 2'b01,
        OP_SEND  = 2'b10,
        OP_ARA   = 2'b11
    } link_op_e;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS    = 10;
    localparam int CONV_INTERVAL_NS = 62_500_000;
    localparam int CONV_CYCLES_DEF  = CONV_INTERVAL_NS / CLK_PERIOD_NS;
    localparam int LINK_HALF_NS     = 80;
    localparam int LINK_HALF_DEF    = LINK_HALF_NS / CLK_PERIOD_NS;

    // ************************************************************
    // Host controller register map
    // ************************************************************
    localparam logic [1:0] HOST_CMD_ADDR    = 2'h0;
    localparam logic [1:0] HOST_DATA_ADDR   = 2'h1;
    localparam logic [1:0] HOST_CTRL_ADDR   = 2'h2;
    localparam logic [1:0] HOST_RESULT_ADDR = 2'h3;

endpackage

// [shared/sensor_link_if.sv]
`timescale 1ns/100ps
interface sensor_link_if;
    logic link_clk;
    logic frame_n;
    logic mosi;
    logic miso;
    logic alert_o;
    logic alert_oe;
    logic alert_n;

    // Open-drain alert wire with pull-up
    assign alert_n = alert_oe ? alert_o : 1'b1;

    modport device (
        input  link_clk,
        input  frame_n,
        input  mosi,
        output miso,
        output alert_o,
        output alert_oe
    );
    modport host (
        output link_clk,
        output frame_n,
        output mosi,
        input  miso,
        input  alert_n
    );
endinterface

// [core/sensor_host.sv]
`timescale 1ns/100ps
module sensor_host
    import thermal_pkg::*;
#(
    parameter int HALF_CYCLES = LINK_HALF_DEF
) (
    input  wire logic       clk,
    input  wire logic       reset,
    sensor_link_if.host     link,
    input  wire logic [1:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output      logic [7:0] rdata
);

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_LOW  = 2'b01,
        H_HIGH = 2'b11,
        H_END  = 2'b10
    } host_state_e;

    if (HALF_CYCLES < 8 || HALF_CYCLES > 255) begin : g_check
        $error("sensor_host: HALF_CYCLES out of range");
    end

    host_state_e state_q;
    logic [7:0]  cmd_q;
    logic [7:0]  data_q;
    logic [7:0]  result_q;
    logic        valid_q;
    logic [7:0]  rdata_q;
    logic [1:0]  miso_q;
    logic [1:0]  alert_q;
    logic [7:0]  div_q;
    logic [4:0]  cnt_q;
    logic [17:0] sh_q;
    logic        lclk_q;
    logic        frame_n_q;
    logic        mosi_q;
    logic        start;
    logic        half;

    assign start = wr && addr == HOST_CTRL_ADDR && state_q == H_IDLE;
    assign half  = div_q == 8'(HALF_CYCLES - 1);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            miso_q  <= 2'h0;
            alert_q <= 2'h3;
        end else begin
            miso_q  <= {miso_q[0], link.miso};
            alert_q <= {alert_q[0], link.alert_n};
        end
    end

    // ************************************************************
    // Command and data registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            cmd_q  <= 8'h00;
            data_q <= 8'h00;
        end else if (wr && addr == HOST_CMD_ADDR) begin
            cmd_q <= wdata;
        end else if (wr && addr == HOST_DATA_ADDR) begin
            data_q <= wdata;
        end
    end

    // Read port, data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else if (rd) begin
            case (addr)
                HOST_CMD_ADDR:    rdata_q <= cmd_q;
                HOST_DATA_ADDR:   rdata_q <= data_q;
                HOST_CTRL_ADDR:   rdata_q <= {5'h00, ~alert_q[1], valid_q,
                                              state_q != H_IDLE};
                HOST_RESULT_ADDR: rdata_q <= result_q;
                default:          rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // ************************************************************
    // Frame generator with divided link clock
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q   <= H_IDLE;
            div_q     <= 8'h00;
            cnt_q     <= 5'h00;
            sh_q      <= 18'h00000;
            lclk_q    <= 1'b0;
            frame_n_q <= 1'b1;
            mosi_q    <= 1'b0;
            result_q  <= 8'h00;
            valid_q   <= 1'b0;
        end else begin
            div_q <= half ? 8'h00 : div_q + 8'h01;
            case (state_q)
                H_IDLE: begin
                    div_q <= 8'h00;
                    if (start) begin
                        state_q   <= H_LOW;
                        frame_n_q <= 1'b0;
                        cnt_q     <= 5'h00;
                        valid_q   <= 1'b0;
                        mosi_q    <= wdata[1];
                        sh_q      <= {wdata[0], cmd_q, data_q, 1'b0};
                    end
                end
                H_LOW: begin
                    if (half) begin
                        lclk_q  <= 1'b1;
                        cnt_q   <= cnt_q + 5'h01;
                        state_q <= H_HIGH;
                        if (cnt_q >= 5'(HEAD_BITS)) begin
                            result_q <= {result_q[6:0], miso_q[1]};
                        end
                    end
                end
                H_HIGH: begin
                    if (half) begin
                        lclk_q <= 1'b0;
                        if (cnt_q == 5'(FRAME_BITS)) begin
                            state_q <= H_END;
                        end else begin
                            mosi_q  <= sh_q[17];
                            sh_q    <= {sh_q[16:0], 1'b0};
                            state_q <= H_LOW;
                        end
                    end
                end
                H_END: begin
                    if (half) begin
                        frame_n_q <= 1'b1;
                        valid_q   <= 1'b1;
                        state_q   <= H_IDLE;
                    end
                end
                default: state_q <= H_IDLE;
            endcase
        end
    end

    assign link.link_clk = lclk_q;
    assign link.frame_n  = frame_n_q;
    assign link.mosi     = mosi_q;
    assign rdata         = rdata_q;

endmodule

// [test/sensor_link_properties.sv]
`timescale 1ns/100ps
module sensor_link_properties
    import thermal_pkg::*;
(
    input logic clk,
    input logic reset,
    input logic link_clk,
    input logic frame_n,
    input logic mosi,
    input logic miso,
    input logic alert_o,
    input logic alert_oe,
    input logic alert_n
);
    logic       prev_q;
    logic [4:0] rises_q;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Link rises seen within a frame
    always_ff @(posedge clk) begin
        prev_q <= link_clk;
        if (reset || frame_n) begin
            rises_q <= 5'h00;
        end else if (link_clk && !prev_q) begin
            rises_q <= rises_q + 5'h01;
        end
    end
    AST_ALERT_LOW:
        assert property (alert_oe |-> !alert_o && !alert_n)
        else $error("alert line not pulled low");
    AST_ALERT_IDLE:
        assert property (!alert_oe |-> alert_n)
        else $error("alert line low while released");
    AST_RELEASE_IN_FRAME:
        assert property ($fell(alert_oe) |-> !frame_n)
        else $error("alert released outside a frame");
    AST_RESET_QUIET:
        assert property ($fell(reset) |-> !alert_oe && frame_n && !miso)
        else $error("link not quiet after reset");
    AST_CLK_IDLE:
        assert property (frame_n |-> !link_clk)
        else $error("link clock moving outside frame");
    AST_HALF_PERIOD:
        assert property ($rose(link_clk) |-> link_clk [*8] ##1 !link_clk)
        else $error("link clock high phase wrong");
    AST_MOSI_STEADY:
        assert property (link_clk && $past(link_clk) |-> $stable(mosi))
        else $error("data moved while link clock high");
    AST_FRAME_BITS:
        assert property ($rose(frame_n) |-> rises_q == FRAME_BITS)
        else $error("frame bit count wrong");
endmodule

// [test/tb_thermal_sensor_register_set.sv]
`timescale 1ns/100ps
module tb_thermal_sensor_register_set;
    import thermal_pkg::*;
    localparam logic [6:0] ADDR = 7'h2A; // Arbitrary value
    logic              clk = 0, reset = 1, wr = 0, rd = 0, adc_done = 0;
    logic              adc_start, open_a = 0, open_b = 0, ac;
    logic [1:0]        addr = '0;
    logic [7:0]        wdata = '0, rdata, got, cfg, hi_a, lo_a, hi_b, lo_b;
    logic [7:0]        st_a, st_b, ca, cb, alert;
    logic signed [9:0] temp_a = 10'sd30, temp_b = 10'sd30;
    int                fail_count = 0, compares = 0, conv_n = 0, t;
    sensor_link_if link ();
    sensor_device #(.CONV_CYCLES(200), .DEV_ADDR(ADDR)) sensor_device_inst (
        .clk(clk), .reset(reset), .link(link), .adc_start(adc_start),
        .adc_done(adc_done), .adc_temp_a(temp_a), .adc_temp_b(temp_b),
        .adc_open_a(open_a), .adc_open_b(open_b));
    sensor_host sensor_host_inst (.clk(clk), .reset(reset), .link(link),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    sensor_link_properties sensor_link_properties_inst (.clk(clk),
        .reset(reset), .link_clk(link.link_clk), .frame_n(link.frame_n),
        .mosi(link.mosi), .miso(link.miso), .alert_o(link.alert_o),
        .alert_oe(link.alert_oe), .alert_n(link.alert_n));
    // ****************************************
    // Clock, converter stand-in, watchdog
    // ****************************************
    always #5 clk = ~clk;
    always @(posedge clk) begin
        adc_done <= 1'b0;
        if (adc_start) begin
            repeat (800) @(posedge clk); // Long enough to poll mid-way
            adc_done <= 1'b1;
            conv_n <= conv_n + 1;
        end
    end
    initial begin
        #800_000;
        fail_count++;
        final_report();
    end
    // Register port cycles and link frames
    task automatic put(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic get(input logic [1:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic xfer(input logic [1:0] op, input logic [7:0] c, d);
        put(HOST_CMD_ADDR, c);
        put(HOST_DATA_ADDR, d);
        put(HOST_CTRL_ADDR, {6'h00, op});
        for (int i = 0; i < 400; i++) begin
            get(HOST_CTRL_ADDR);
            if (got[0] === 1'b0) break;
        end
        chk(8'h00, {7'h00, got[0]});
        get(HOST_RESULT_ADDR);
    endtask
    task automatic chk(input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic final_report();
        if (fail_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Model value; host takes any below-zero reading as 0
    function automatic logic [7:0] sat(input logic signed [9:0] v);
        return (v < 0) ? 8'h00 : (v > 127) ? TEMP_MAX : {1'b0, v[6:0]};
    endfunction
    // Main sequence against the reference model
    initial begin
        t = $urandom(32'hA22CEDDB);
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        xfer(OP_READ, CMD_CFG_RD, 8'h00);
        chk(CFG_RST, got);
        xfer(OP_READ, CMD_HIGH_B, 8'h00);
        chk(LIMIT_HIGH_RST, got);
        xfer(OP_READ, 8'h05, 8'h00);
        chk(8'h00, got);
        xfer(OP_READ, CMD_TEMP_A_RD, 8'h00);
        chk(sat(temp_a), got);
        st_a = 0;
        st_b = 0;
        alert = 0;
        for (int n = 0; n < 10; n++) begin
            t = $urandom;
            cfg = {t[2], 1'b1, 4'h0, t[1:0]};
            {hi_a, lo_a, hi_b, lo_b} = $urandom & 32'h7F7F7F7F;
            xfer(OP_WRITE, CMD_CFG_WR, cfg);
            xfer(OP_WRITE, CMD_HIGH_A_WR, hi_a);
            xfer(OP_WRITE, CMD_LOW_A_WR, lo_a);
            xfer(OP_WRITE, CMD_HIGH_B, hi_b);
            xfer(OP_WRITE, CMD_LOW_B, lo_b);
            temp_a <= 10'($urandom_range(200, 0)) - 10'sd40;
            temp_b <= 10'($urandom_range(200, 0)) - 10'sd40;
            open_a <= ($urandom_range(3, 0) == 0);
            open_b <= ($urandom_range(3, 0) == 0);
            t = conv_n;
            xfer(OP_SEND, CMD_ONE_SHOT, 8'h00);
            xfer(OP_READ, CMD_STAT_A_RD, 8'h00);
            chk(st_a | 8'h80, got);
            xfer(OP_SEND, CMD_ONE_SHOT, 8'h00);
            repeat (400) if (conv_n == t) @(posedge clk);
            ca = {3'h0, sat(temp_a) >= hi_a, sat(temp_a) <= lo_a, open_a, 2'h0};
            cb = {3'h0, sat(temp_b) >= hi_b, sat(temp_b) <= lo_b, open_b, 2'h0};
            st_a = st_a | ca;
            st_b = st_b | cb;
            ac = (!cfg[1] && ca[4:3] != 0) || ca[2] || cb[2]
                || (!cfg[0] && cb[4:3] != 0);
            if (ac && !cfg[7]) alert = 1;
            xfer(OP_READ, CMD_TEMP_A_RD, 8'h00);
            chk(sat(temp_a), got);
            xfer(OP_READ, CMD_TEMP_B_RD, 8'h00);
            chk(sat(temp_b), got);
            xfer(OP_READ, CMD_STAT_A_RD, 8'h00);
            chk(st_a, got);
            st_a = ca;
            xfer(OP_READ, CMD_STAT_B_RD, 8'h00);
            chk(st_b | alert, got);
            st_b = cb;
            xfer(OP_ARA, 8'h00, 8'h00);
            chk((alert[0] && !cfg[7]) ? {ADDR, 1'b0} : NO_ANSWER, got);
            if (!cfg[7] && !ac) alert = 0;
            get(HOST_CTRL_ADDR);
            chk(alert, {7'h00, got[2]});
            chk(8'h01, 8'(conv_n - t));
        end
        final_report();
    end
endmodule
